// ==== inc/tmr_regs.svh ====
// register offsets, field positions, reset values and divider counts of the timer
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// ==========================================================
// register byte offsets
`define TMR_OFF_CTRL_A     8'h00
`define TMR_OFF_CTRL_B     8'h04
`define TMR_OFF_COUNT      8'h08
`define TMR_OFF_CMP_A      8'h0c
`define TMR_OFF_CMP_B      8'h10
`define TMR_OFF_FLAGS      8'h14
`define TMR_OFF_PORT       8'h18

// ==========================================================
// field positions
`define TMR_CTRL_A_MODE_LSB    0
`define TMR_CTRL_A_ACT_A_LSB   4
`define TMR_CTRL_A_ACT_B_LSB   6
`define TMR_CTRL_B_CSEL_LSB    0
`define TMR_CTRL_B_FORCE_B     6
`define TMR_CTRL_B_FORCE_A     7
`define TMR_FLAGS_OVF          0
`define TMR_FLAGS_CMP_A        1
`define TMR_FLAGS_CMP_B        2
`define TMR_PORT_DATA_LSB      0
`define TMR_PORT_DIR_LSB       2

// ==========================================================
// reset values and count limits
`define TMR_RST_BYTE       8'h00
`define TMR_RST_MODE       3'h0
`define TMR_RST_CSEL       3'h0
`define TMR_RST_ACT        2'h0
`define TMR_COUNT_MAX      8'hff
`define TMR_COUNT_BOTTOM   8'h00

// ==========================================================
// prescale dividers as terminal counts of a 10-bit counter
`define TMR_DIV8_MASK      10'h007
`define TMR_DIV64_MASK     10'h03f
`define TMR_DIV256_MASK    10'h0ff
`define TMR_DIV1024_MASK   10'h3ff

`endif

// ==== inc/tmr_pkg.sv ====
// types shared by the timer files
package tmr_pkg;

   // ==========================================================
   // waveform modes
   typedef enum logic [2:0] {
      TMR_NORMAL  = 3'b000,
      TMR_PC_PWM  = 3'b001,
      TMR_CTC     = 3'b010,
      TMR_FAST    = 3'b011,
      TMR_RSV4    = 3'b100,
      TMR_PC_TOP  = 3'b101,
      TMR_RSV6    = 3'b110,
      TMR_FAST_TOP = 3'b111
   } tmr_wave_t;

   // clock sources
   typedef enum logic [2:0] {
      TMR_CS_STOP = 3'b000,
      TMR_CS_DIV1 = 3'b001,
      TMR_CS_DIV8 = 3'b010,
      TMR_CS_DIV64 = 3'b011,
      TMR_CS_DIV256 = 3'b100,
      TMR_CS_DIV1024 = 3'b101,
      TMR_CS_EXT_FALL = 3'b110,
      TMR_CS_EXT_RISE = 3'b111
   } tmr_csel_t;

   // output actions at a compare match
   typedef enum logic [1:0] {
      TMR_ACT_NONE   = 2'b00,
      TMR_ACT_TOGGLE = 2'b01,
      TMR_ACT_CLEAR  = 2'b10,
      TMR_ACT_SET    = 2'b11
   } tmr_act_t;

   // one apb request as seen by the slave
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } tmr_apb_req_t;

   // per-channel pin configuration
   typedef struct packed {
      tmr_act_t    action;
      logic        port_data;
      logic        dir;
   } tmr_chan_t;

endpackage : tmr_pkg

// ==== rtl/tmr_prescaler.sv ====
// timer tick generator: prescaler and external clock edge detection
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_prescaler
   import tmr_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      ce,
   input  wire tmr_csel_t csel,
   input  wire logic      ext_pin,
   output var  logic      tick
);

   logic [9:0] div_reg;
   logic       sync1_reg;
   logic       sync2_reg;
   logic       prev_reg;
   logic       ext_rise;
   logic       ext_fall;
   logic       at8;
   logic       at64;
   logic       at256;
   logic       at1024;

   // ==========================================================
   // free-running divider and external pin synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_reg   <= 10'h000;
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else if (ce) begin
         div_reg   <= div_reg + 10'h001;
         sync1_reg <= ext_pin;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   assign ext_rise = sync2_reg & ~prev_reg;
   assign ext_fall = ~sync2_reg & prev_reg;
   assign at8      = (div_reg & `TMR_DIV8_MASK) == `TMR_DIV8_MASK;
   assign at64     = (div_reg & `TMR_DIV64_MASK) == `TMR_DIV64_MASK;
   assign at256    = (div_reg & `TMR_DIV256_MASK) == `TMR_DIV256_MASK;
   assign at1024   = div_reg == `TMR_DIV1024_MASK;

   // ==========================================================
   // one-cycle tick of the selected source
   always_comb begin
      case (csel)
         TMR_CS_STOP:     tick = 1'b0;
         TMR_CS_DIV1:     tick = ce;
         TMR_CS_DIV8:     tick = ce & at8;
         TMR_CS_DIV64:    tick = ce & at64;
         TMR_CS_DIV256:   tick = ce & at256;
         TMR_CS_DIV1024:  tick = ce & at1024;
         TMR_CS_EXT_FALL: tick = ce & ext_fall;
         TMR_CS_EXT_RISE: tick = ce & ext_rise;
         default:         tick = 1'b0;
      endcase
   end

endmodule : tmr_prescaler
`default_nettype wire

// ==== rtl/tmr_timer.sv ====
// 8-bit timer: counter, two compare channels, output pins and apb registers
// Function
// - counter write blocks matches for next tick
// - mode change keeps compare output bits
// - output action takes effect without buffering
// - reset clears compare output bits
// - nonzero action overrides port output value
// - pin shows bit only when direction output
// - override depends only on output action
// - action zero leaves output bit unchanged
// - action at next match; force acts now in modes zero and two
// - only mode field steers counting
// - mode zero counts up, wraps at max
// - normal mode overflow set when count zero
// - serviced overflow interrupt clears flag
// - mode two clears after compare A
// - low compare A waits for wrap
// - compare flag A set at top
// - action one toggles output at match
// - toggle rate follows prescale and compare
// - clear mode overflow on max to zero
// - equality sets compare flag next tick
// - counter write beats clear and count
// - clock select zero stops counter
// - writing one clears a flag
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_timer
   import tmr_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        EXT_CLK_PIN,
   input  wire logic        OVF_SERVICED,
   input  wire logic        CMPA_SERVICED,
   input  wire logic        CMPB_SERVICED,
   output var  logic [1:0]  PIN_OUT,
   output var  logic [1:0]  PIN_OE,
   output var  logic        OVF_FLAG,
   output var  logic        CMPA_FLAG,
   output var  logic        CMPB_FLAG
);

   localparam int NCH = 2;

   tmr_apb_req_t req;
   logic         setup;
   logic         access_done;
   logic         wr;
   logic         hit_ctrl_a;
   logic         hit_ctrl_b;
   logic         hit_count;
   logic         hit_flags;
   logic         hit_port;
   logic         hit_cmp [NCH];
   logic         mapped;

   tmr_wave_t    mode_reg;
   tmr_csel_t    csel_reg;
   tmr_act_t     act_reg [NCH];
   logic [1:0]   port_data_reg;
   logic [1:0]   dir_reg;
   logic [7:0]   count_reg;
   logic [7:0]   count_next;
   logic         block_reg;
   logic         ovf_reg;
   logic [NCH-1:0] cmpf_reg;
   logic [7:0]   cmp_val [NCH];
   logic [NCH-1:0] oc_bit;
   logic [NCH-1:0] match;
   logic [NCH-1:0] force_strobe;
   logic [NCH-1:0] serviced;

   logic         tick;
   logic         non_pwm;
   logic         ctc_clear;
   logic         ovf_set;
   logic [31:0]  rdata_mux;
   logic [31:0]  prdata_next;
   logic [1:0]   pin_out_next;

   // ==========================================================
   // apb decode
   assign req         = '{sel: PSEL, enable: PENABLE, write: PWRITE,
                          addr: PADDR, wdata: PWDATA};
   assign setup       = req.sel & ~req.enable;
   assign access_done = req.sel & req.enable & PREADY;
   assign wr          = access_done & req.write;
   assign hit_ctrl_a  = req.addr == `TMR_OFF_CTRL_A;
   assign hit_ctrl_b  = req.addr == `TMR_OFF_CTRL_B;
   assign hit_count   = req.addr == `TMR_OFF_COUNT;
   assign hit_cmp[0]  = req.addr == `TMR_OFF_CMP_A;
   assign hit_cmp[1]  = req.addr == `TMR_OFF_CMP_B;
   assign hit_flags   = req.addr == `TMR_OFF_FLAGS;
   assign hit_port    = req.addr == `TMR_OFF_PORT;
   assign mapped      = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp[0]
                        | hit_cmp[1] | hit_flags | hit_port;
   assign serviced    = {CMPB_SERVICED, CMPA_SERVICED};

   // ==========================================================
   // read data, captured in the setup cycle
   always_comb begin
      rdata_mux = 32'h0000_0000;
      if (hit_ctrl_a) begin
         rdata_mux[`TMR_CTRL_A_MODE_LSB +: 3]  = mode_reg;
         rdata_mux[`TMR_CTRL_A_ACT_A_LSB +: 2] = act_reg[0];
         rdata_mux[`TMR_CTRL_A_ACT_B_LSB +: 2] = act_reg[1];
      end else if (hit_ctrl_b) begin
         rdata_mux[`TMR_CTRL_B_CSEL_LSB +: 3] = csel_reg;
      end else if (hit_count) begin
         rdata_mux[7:0] = count_reg;
      end else if (hit_cmp[0]) begin
         rdata_mux[7:0] = cmp_val[0];
      end else if (hit_cmp[1]) begin
         rdata_mux[7:0] = cmp_val[1];
      end else if (hit_flags) begin
         rdata_mux[`TMR_FLAGS_OVF]   = ovf_reg;
         rdata_mux[`TMR_FLAGS_CMP_A] = cmpf_reg[0];
         rdata_mux[`TMR_FLAGS_CMP_B] = cmpf_reg[1];
      end else if (hit_port) begin
         rdata_mux[`TMR_PORT_DATA_LSB +: 2] = port_data_reg;
         rdata_mux[`TMR_PORT_DIR_LSB +: 2]  = dir_reg;
      end
   end

   assign prdata_next = setup ? rdata_mux : PRDATA;

   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PRDATA  <= prdata_next;
         PREADY  <= setup;
         PSLVERR <= setup & ~mapped;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         mode_reg      <= tmr_wave_t'(`TMR_RST_MODE);
         csel_reg      <= tmr_csel_t'(`TMR_RST_CSEL);
         act_reg[0]    <= tmr_act_t'(`TMR_RST_ACT);
         act_reg[1]    <= tmr_act_t'(`TMR_RST_ACT);
         port_data_reg <= 2'h0;
         dir_reg       <= 2'h0;
      end else if (CE) begin
         if (wr && hit_ctrl_a) begin
            mode_reg   <= tmr_wave_t'(req.wdata[`TMR_CTRL_A_MODE_LSB +: 3]);
            act_reg[0] <= tmr_act_t'(req.wdata[`TMR_CTRL_A_ACT_A_LSB +: 2]);
            act_reg[1] <= tmr_act_t'(req.wdata[`TMR_CTRL_A_ACT_B_LSB +: 2]);
         end
         if (wr && hit_ctrl_b) begin
            csel_reg <= tmr_csel_t'(req.wdata[`TMR_CTRL_B_CSEL_LSB +: 3]);
         end
         if (wr && hit_port) begin
            port_data_reg <= req.wdata[`TMR_PORT_DATA_LSB +: 2];
            dir_reg       <= req.wdata[`TMR_PORT_DIR_LSB +: 2];
         end
      end
   end

   // ==========================================================
   // timer tick
   tmr_prescaler u_presc (
      .clk     (CLOCK),
      .rst_n   (RESETN),
      .ce      (CE),
      .csel    (csel_reg),
      .ext_pin (EXT_CLK_PIN),
      .tick    (tick)
   );

   // ==========================================================
   // counter unit
   assign non_pwm   = (mode_reg == TMR_NORMAL) | (mode_reg == TMR_CTC);
   assign ctc_clear = (mode_reg == TMR_CTC) & (count_reg == cmp_val[0]);
   // a counter write in the same cycle wins, so no wrap and no overflow then
   assign ovf_set   = tick & ~(wr & hit_count)
                      & (count_reg == `TMR_COUNT_MAX);

   always_comb begin
      count_next = count_reg;
      if (wr && hit_count) begin
         count_next = req.wdata[7:0];
      end else if (tick) begin
         if (ctc_clear) begin
            count_next = `TMR_COUNT_BOTTOM;
         end else begin
            count_next = count_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         count_reg <= `TMR_RST_BYTE;
         block_reg <= 1'b0;
      end else if (CE) begin
         count_reg <= count_next;
         if (wr && hit_count) begin
            block_reg <= 1'b1;
         end else if (tick) begin
            block_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // overflow flag: hardware set beats clear
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         ovf_reg <= 1'b0;
      end else if (CE) begin
         ovf_reg <= (ovf_reg
                     & ~(wr & hit_flags & req.wdata[`TMR_FLAGS_OVF])
                     & ~OVF_SERVICED)
                    | ovf_set;
      end
   end

   // ==========================================================
   // compare channels
   for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      logic [7:0] cmp_reg;
      logic       oc_reg;
      logic       oc_next;
      logic       act_now;
      tmr_act_t   act_sel;
      tmr_chan_t  cfg;

      assign cfg     = '{action: act_reg[ch], port_data: port_data_reg[ch],
                         dir: dir_reg[ch]};
      assign cmp_val[ch] = cmp_reg;
      assign oc_bit[ch]  = oc_reg;
      assign match[ch]   = tick & ~block_reg & (count_reg == cmp_reg);
      assign force_strobe[ch] = wr & hit_ctrl_b & non_pwm
                                & req.wdata[`TMR_CTRL_B_FORCE_A - ch];
      assign act_now = match[ch] | force_strobe[ch];
      assign act_sel = cfg.action;

      always_comb begin
         oc_next = oc_reg;
         if (act_now) begin
            case (act_sel)
               TMR_ACT_NONE:   oc_next = oc_reg;
               TMR_ACT_TOGGLE: oc_next = ~oc_reg;
               TMR_ACT_CLEAR:  oc_next = 1'b0;
               TMR_ACT_SET:    oc_next = 1'b1;
               default:        oc_next = oc_reg;
            endcase
         end
      end

      // override depends on the action field alone, not the mode
      assign pin_out_next[ch] = (cfg.action != TMR_ACT_NONE)
                                ? oc_next : cfg.port_data;

      always_ff @(posedge CLOCK) begin
         if (!RESETN) begin
            cmp_reg      <= `TMR_RST_BYTE;
            oc_reg       <= 1'b0;
            cmpf_reg[ch] <= 1'b0;
            PIN_OUT[ch]  <= 1'b0;
            PIN_OE[ch]   <= 1'b0;
         end else if (CE) begin
            if (wr && hit_cmp[ch]) begin
               cmp_reg <= req.wdata[7:0];
            end
            oc_reg       <= oc_next;
            cmpf_reg[ch] <= (cmpf_reg[ch]
                             & ~(wr & hit_flags
                                 & req.wdata[`TMR_FLAGS_CMP_A + ch])
                             & ~serviced[ch])
                            | match[ch];
            PIN_OUT[ch]  <= pin_out_next[ch];
            PIN_OE[ch]   <= cfg.dir;
         end
      end
   end

   // ==========================================================
   // flag outputs
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         OVF_FLAG  <= 1'b0;
         CMPA_FLAG <= 1'b0;
         CMPB_FLAG <= 1'b0;
      end else if (CE) begin
         OVF_FLAG  <= ovf_reg;
         CMPA_FLAG <= cmpf_reg[0];
         CMPB_FLAG <= cmpf_reg[1];
      end
   end

endmodule : tmr_timer
`default_nettype wire

// ==== dv/tmr_cpu_model.sv ====
// cpu-side model: apb master and interrupt service pulses
`timescale 1ns/10ps
`default_nettype none

module tmr_cpu_model
   import tmr_pkg::*;
(
   input  wire logic         clk,
   input  wire logic [31:0]  prdata,
   input  wire logic         pready,
   input  wire logic         pslverr,
   output var  tmr_apb_req_t req,
   output var  logic [2:0]   svc
);
   initial begin
      req = '0;
      svc = 3'h0;
   end

   // ==========================================================
   // one transfer: setup, access held until ready, then release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge clk);
      req <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.enable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      err = pslverr;
      req <= '0;
   endtask : xfer

   // one-cycle service pulse, bit0 overflow, bit1 compare a, bit2 compare b
   task automatic service(input logic [2:0] m);
      @(posedge clk);
      svc <= m;
      @(posedge clk);
      svc <= 3'h0;
   endtask : service
endmodule : tmr_cpu_model
`default_nettype wire

// ==== dv/tmr_timer_checker.sv ====
// assertions on the timer top-level ports
`timescale 1ns/10ps
`default_nettype none

module tmr_timer_checker
   import tmr_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        RESETN,
   input wire logic        CE,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        EXT_CLK_PIN,
   input wire logic        OVF_SERVICED,
   input wire logic        CMPA_SERVICED,
   input wire logic        CMPB_SERVICED,
   input wire logic [1:0]  PIN_OUT,
   input wire logic [1:0]  PIN_OE,
   input wire logic        OVF_FLAG,
   input wire logic        CMPA_FLAG,
   input wire logic        CMPB_FLAG
);
   wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE;
   wire logic port_wr = wr_done && (PADDR == 8'h18);
   wire logic flag_wr = wr_done && (PADDR == 8'h14);
   wire logic clr_ovf = OVF_SERVICED || (flag_wr && PWDATA[0]);
   wire logic clr_cma = CMPA_SERVICED || (flag_wr && PWDATA[1]);

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);

   // ==========================================================
   // bus handshake
   sequence s_setup;
      PSEL && !PENABLE && CE;
   endsequence
   sequence s_access;
      PSEL && PENABLE && PREADY;
   endsequence
   chk_ready_setup: assert property (s_setup |=> s_access) else $error("no ready after setup");
   chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
   chk_err_ready: assert property (PSLVERR |-> s_access) else $error("error without ready");
   chk_err_rdata: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("unmapped read not zero");

   // ==========================================================
   // outputs and flags
   chk_reset_outs: assert property ($rose(RESETN) |-> PIN_OUT == 2'h0 && !OVF_FLAG && !CMPA_FLAG)
      else $error("outputs not cleared by reset");
   chk_oe_cause: assert property ($changed(PIN_OE) |-> $past(port_wr) || $past(port_wr, 2))
      else $error("enable changed without port write");
   chk_ovf_hold: assert property ($fell(OVF_FLAG) |-> $past(clr_ovf) || $past(clr_ovf, 2) || !$past(RESETN))
      else $error("overflow flag fell by itself");
   chk_cmpa_hold: assert property ($fell(CMPA_FLAG) |-> $past(clr_cma) || $past(clr_cma, 2) || !$past(RESETN))
      else $error("compare flag fell by itself");
   chk_cmpa_clear: assert property (flag_wr && PWDATA[1] |-> ##2 !CMPA_FLAG)
      else $error("compare flag not cleared by write");
   chk_svc_clear: assert property (OVF_SERVICED |-> ##2 !OVF_FLAG)
      else $error("overflow flag not cleared by service");
endmodule : tmr_timer_checker

bind tmr_timer tmr_timer_checker u_chk (.CLOCK, .RESETN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PRDATA, .PREADY, .PSLVERR, .EXT_CLK_PIN, .OVF_SERVICED, .CMPA_SERVICED,
   .CMPB_SERVICED, .PIN_OUT, .PIN_OE, .OVF_FLAG, .CMPA_FLAG, .CMPB_FLAG);
`default_nettype wire

// ==== dv/tmr_timer_tb.sv ====
// self-checking testbench of the timer
`timescale 1ns/10ps
`default_nettype none

module tmr_timer_tb
   import tmr_pkg::*;
;
   localparam logic [7:0] off_ctla = 8'h00, off_ctlb = 8'h04, off_cnt = 8'h08;
   localparam logic [7:0] off_cmpa = 8'h0c, off_flg = 8'h14, off_port = 8'h18;
   logic         clock, resetn, e, ovf_f, cmpa_f, cmpb_f, pready, pslverr, ce, ext;
   tmr_apb_req_t req;
   logic [31:0]  prdata, q;
   logic [2:0]   svc;
   logic [1:0]   pin_out, pin_oe;
   int           err_total, total_checks, cycles, n;
   logic [2:0]   cs [3] = '{3'h1, 3'h1, 3'h2};
   logic [7:0]   tp [3] = '{8'h00, 8'h03, 8'h01};
   int           per [3] = '{1, 4, 16};
   logic [1:0]   act [3] = '{2'h3, 2'h2, 2'h1};

   tmr_timer u_dut (.CLOCK(clock), .RESETN(resetn), .CE(ce), .PSEL(req.sel),
      .PENABLE(req.enable), .PWRITE(req.write), .PADDR(req.addr), .PWDATA(req.wdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_CLK_PIN(ext),
      .OVF_SERVICED(svc[0]), .CMPA_SERVICED(svc[1]), .CMPB_SERVICED(svc[2]),
      .PIN_OUT(pin_out), .PIN_OE(pin_oe), .OVF_FLAG(ovf_f), .CMPA_FLAG(cmpa_f), .CMPB_FLAG(cmpb_f));
   tmr_cpu_model u_cpu (.clk(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req(req), .svc(svc));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // ==========================================================
   // tasks
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      u_cpu.xfer(1'b1, a, d, q, e);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x);
      u_cpu.xfer(1'b0, a, 32'h0, q, e);
      chk($sformatf("register %h", a), q, x);
   endtask : rd
   task gap(input int c);
      repeat (c) @(posedge clock);
   endtask : gap
   task period(output int k);
      logic p;
      @(posedge clock);
      p = pin_out[0];
      while (pin_out[0] === p) @(posedge clock);
      p = pin_out[0];
      k = 0;
      while (pin_out[0] === p) begin
         @(posedge clock);
         k++;
      end
   endtask : period
   task tally_and_finish;
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      ext = 1'b0;
      err_total = 0;
      total_checks = 0;
      cycles = 0;
      gap(6);
      resetn <= 1'b1;
      for (int a = 0; a < 'h1c; a += 4) rd(a[7:0], 32'h0);
      u_cpu.xfer(1'b0, 8'h1c, 32'h0, q, e);
      chk("unmapped read", {q[30:0], e}, 32'h1);
      wr(off_cnt, 32'h5a);
      gap(20);
      rd(off_cnt, 32'h5a);
      // count written equal to compare on purpose: that match must be lost
      wr(off_cmpa, 32'h20);
      wr(off_cnt, 32'h20);
      wr(off_ctlb, 32'h1);
      wr(off_ctlb, 32'h0);
      rd(off_flg, 32'h0);
      wr(off_ctlb, 32'h1);
      gap(300);
      wr(off_ctlb, 32'h0);
      // compare b sits at zero, so the wrap also sets its flag
      rd(off_flg, 32'h7);
      chk("compare flag a", cmpa_f, 32'h1);
      chk("flag pins ovf b", {ovf_f, cmpb_f}, 32'h3);
      wr(off_flg, 32'h0);
      rd(off_flg, 32'h7);
      wr(off_flg, 32'h6);
      rd(off_flg, 32'h1);
      u_cpu.service(3'h1);
      rd(off_flg, 32'h0);
      // output bit set up before the pin turns to output
      wr(off_port, 32'h1);
      wr(off_ctla, 32'h20);
      wr(off_ctlb, 32'h80);
      wr(off_port, 32'h5);
      gap(3);
      chk("pin a", pin_out[0], 32'h0);
      chk("pin enable", pin_oe, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr(off_ctla, {26'h0, act[i], 4'h0});
         wr(off_ctlb, 32'h80);
         gap(3);
         chk("forced pin a", pin_out[0], {31'h0, i != 1});
      end
      wr(off_port, 32'h4);
      wr(off_ctla, 32'h0);
      wr(off_ctlb, 32'h80);
      gap(3);
      chk("port pin a", pin_out[0], 32'h0);
      wr(off_ctla, 32'h12);
      gap(3);
      chk("kept pin a", pin_out[0], 32'h1);
      wr(off_port, 32'hc);
      wr(off_ctla, 32'hd2);
      wr(off_ctlb, 32'h40);
      gap(3);
      chk("forced pin b", pin_out, 32'h3);
      chk("pin enables", pin_oe, 32'h3);
      for (int i = 0; i < 3; i++) begin
         wr(off_ctlb, 32'h0);
         wr(off_cmpa, {24'h0, tp[i]});
         wr(off_cnt, 32'h0);
         wr(off_flg, 32'h7);
         wr(off_ctlb, {29'h0, cs[i]});
         period(n);
         chk("toggle period", n, per[i]);
         wr(off_ctlb, 32'h0);
         u_cpu.xfer(1'b0, off_cnt, 32'h0, q, e);
         chk("count at top", q <= {24'h0, tp[i]}, 32'h1);
         u_cpu.xfer(1'b0, off_flg, 32'h0, q, e);
         chk("flags at top", q & 32'h3, 32'h2);
      end
      wr(off_cmpa, 32'h10);
      wr(off_cnt, 32'h20);
      wr(off_flg, 32'h7);
      wr(off_ctlb, 32'h1);
      gap(260);
      wr(off_ctlb, 32'h0);
      rd(off_flg, 32'h7);
      // external falling then rising edges, three of each
      wr(off_ctla, 32'h0);
      for (int i = 6; i < 8; i++) begin
         wr(off_cnt, 32'h0);
         wr(off_ctlb, i);
         repeat (3) begin
            ext <= 1'b1;
            gap(4);
            ext <= 1'b0;
            gap(4);
         end
         wr(off_ctlb, 32'h0);
         rd(off_cnt, 32'h3);
      end
      // clock enable low freezes counting; three ticks follow it
      wr(off_cnt, 32'h0);
      wr(off_ctlb, 32'h1);
      ce <= 1'b0;
      gap(50);
      ce <= 1'b1;
      wr(off_ctlb, 32'h0);
      rd(off_cnt, 32'h3);
      wr(off_ctlb, 32'h1);
      gap(10);
      resetn <= 1'b0;
      gap(6);
      resetn <= 1'b1;
      gap(2);
      chk("pins after reset", pin_out, 32'h0);
      rd(off_ctla, 32'h0);
      tally_and_finish();
   end
endmodule : tmr_timer_tb
`default_nettype wire
